// >>> hdl/usb_ctl_pkg.sv
package usb_ctl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W       = 12;
    localparam logic [11:0] CTRL_OFF    = 12'h000;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h004;
    localparam logic [11:0] IRQ_CLR_OFF = 12'h008;
    localparam logic [11:0] IRQ_EN_OFF  = 12'h00C;
    localparam logic [11:0] TOKEN_OFF   = 12'h010;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int JLIVE_BIT  = 7;
    localparam int SE0_BIT    = 6;
    localparam int PACKET_PROCESSING_DISABLE_BIT = 5;
    localparam int BUSRST_BIT = 4;
    localparam int HOST_CAPABILITY_ENABLE_BIT = 3;
    localparam int RESUME_BIT = 2;
    localparam int STORE1_BIT = 1;
    localparam int STORE0_BIT = 0;
    localparam int TOKEN_W    = 8;

    // ------------------------------------------------------------------
    // Event bits of status, clear and enable registers
    // ------------------------------------------------------------------
    localparam int EV_SETUP   = 0;
    localparam int EV_TOKDONE = 1;
    localparam int EV_EOPDONE = 2;
    localparam int EV_W       = 3;

    // ------------------------------------------------------------------
    // Timing: low-speed end of packet after resume
    // ------------------------------------------------------------------
    localparam int CLK_NS     = 25;
    localparam int LS_SE0_NS  = 1334;
    localparam int LS_J_NS    = 667;
    localparam int CNT_W      = 8;
    localparam logic [7:0] LS_SE0_CYC =
        8'((LS_SE0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] LS_J_CYC =
        8'((LS_J_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {
        EOP_IDLE = 3'h1,
        EOP_SE0  = 3'h2,
        EOP_J    = 3'h4
    } eop_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic rx_j;
        logic rx_se0;
        logic setup_seen;
        logic token_done;
    } link_in_s;

    typedef struct packed {
        logic               host_mode;
        logic               bus_reset_drive;
        logic               resume_drive;
        logic               eop_se0_drive;
        logic               eop_j_drive;
        logic               packet_halt;
        logic               host_logic_reset;
        logic               token_start;
        logic [TOKEN_W-1:0] token_cmd;
    } link_out_s;

    typedef struct packed {
        apb_rsp_s          rsp;
        link_out_s         lo;
        logic              irq;
        logic              j_live;
        logic              se0_live;
        logic              pkt_dis;
        logic              bus_reset;
        logic              host_en;
        logic              resume;
        logic              store1;
        logic              store0;
        logic              busy;
        eop_e              eop;
        logic [CNT_W-1:0]  cnt;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   enable;
    } state_s;

endpackage

// >>> hdl/usb_control_register_logic.sv
`timescale 1ns/1ps
module usb_control_register_logic
    import usb_ctl_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire apb_req_s  apb_i,
    output apb_rsp_s       apb_o,
    input  wire link_in_s  link_i,
    output link_out_s      link_o,
    output logic           irq_o
);

    state_s s;
    state_s n;

    logic access;
    logic done;
    logic wr;
    logic tok_ok;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [7:0] ctrl_rd;

    assign apb_o  = s.rsp;
    assign link_o = s.lo;
    assign irq_o  = s.irq;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n       = s;
        ev      = '0;
        clr     = '0;
        access  = apb_i.psel && apb_i.penable;
        done    = access && s.rsp.pready;
        wr      = done && apb_i.pwrite;
        tok_ok  = wr && (apb_i.paddr == TOKEN_OFF) && s.host_en && !s.busy;
        n.j_live   = link_i.rx_j;
        n.se0_live = link_i.rx_se0;
        n.lo.token_start      = 1'b0;
        n.lo.host_logic_reset = 1'b0;

        // Bit 5 is shared: busy in host mode, halt flag in device mode
        ctrl_rd = {s.j_live, s.se0_live,
                   s.host_en ? s.busy : s.pkt_dis,
                   s.bus_reset, s.host_en, s.resume,
                   s.store1, s.store0};

        // One wait state keeps pready straight from a flop
        n.rsp.pready = access && !s.rsp.pready;
        if (access && !s.rsp.pready) begin
            n.rsp.pslverr = 1'b0;
            n.rsp.prdata  = '0;
            if (apb_i.paddr == CTRL_OFF) begin
                n.rsp.prdata = {24'h000000, ctrl_rd};
            end else if (apb_i.paddr == IRQ_STAT_OFF) begin
                n.rsp.prdata = {29'h00000000, s.status};
            end else if (apb_i.paddr == IRQ_EN_OFF) begin
                n.rsp.prdata = {29'h00000000, s.enable};
            end else if (apb_i.paddr == IRQ_CLR_OFF) begin
                n.rsp.prdata = '0;
            end else if (apb_i.paddr == TOKEN_OFF) begin
                n.rsp.prdata = {24'h000000, s.lo.token_cmd};
            end else begin
                n.rsp.pslverr = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wr && apb_i.paddr == CTRL_OFF) begin
            n.bus_reset = apb_i.pwdata[BUSRST_BIT];
            n.host_en   = apb_i.pwdata[HOST_CAPABILITY_ENABLE_BIT];
            n.resume    = apb_i.pwdata[RESUME_BIT];
            n.store1    = apb_i.pwdata[STORE1_BIT];
            n.store0    = apb_i.pwdata[STORE0_BIT];
            if (!s.host_en) begin
                n.pkt_dis = apb_i.pwdata[PACKET_PROCESSING_DISABLE_BIT];
            end
        end else if (wr && apb_i.paddr == IRQ_EN_OFF) begin
            n.enable = apb_i.pwdata[EV_W-1:0];
        end else if (wr && apb_i.paddr == IRQ_CLR_OFF) begin
            clr = apb_i.pwdata[EV_W-1:0];
        end

        // In device mode a SETUP token halts processing; the set beats a clearing write
        if (!s.host_en && link_i.setup_seen) begin
            n.pkt_dis    = 1'b1;
            ev[EV_SETUP] = 1'b1;
        end

        // Token busy; a write while busy is dropped, not queued
        if (tok_ok) begin
            n.busy         = 1'b1;
            n.lo.token_start = 1'b1;
            n.lo.token_cmd = apb_i.pwdata[TOKEN_W-1:0];
        end else if (s.busy && link_i.token_done) begin
            n.busy         = 1'b0;
            ev[EV_TOKDONE] = 1'b1;
        end

        // --------------------------------------------------------------
        // Low-speed end of packet after resume
        // --------------------------------------------------------------
        case (s.eop)
            EOP_IDLE: begin
                if (s.host_en && s.resume && !n.resume) begin
                    n.eop = EOP_SE0;
                    n.cnt = LS_SE0_CYC - 8'h01;
                end
            end
            EOP_SE0: begin
                if (s.cnt == '0) begin
                    n.eop = EOP_J;
                    n.cnt = LS_J_CYC - 8'h01;
                end else begin
                    n.cnt = s.cnt - 8'h01;
                end
            end
            EOP_J: begin
                if (s.cnt == '0) begin
                    n.eop          = EOP_IDLE;
                    ev[EV_EOPDONE] = 1'b1;
                end else begin
                    n.cnt = s.cnt - 8'h01;
                end
            end
            default: begin
                n.eop = EOP_IDLE;
                n.cnt = '0;
            end
        endcase

        // Host toggle wins over token busy, token start and the EOP sequence
        if (n.host_en != s.host_en) begin
            n.busy                = 1'b0;
            n.eop                 = EOP_IDLE;
            n.cnt                 = '0;
            n.lo.token_start      = 1'b0;
            n.lo.host_logic_reset = 1'b1;
        end

        // --------------------------------------------------------------
        // Outputs and interrupt
        // --------------------------------------------------------------
        n.lo.host_mode       = n.host_en;
        n.lo.bus_reset_drive = n.host_en && n.bus_reset;
        n.lo.resume_drive    = n.resume;
        n.lo.eop_se0_drive   = (n.eop == EOP_SE0);
        n.lo.eop_j_drive     = (n.eop == EOP_J);
        n.lo.packet_halt     = !n.host_en && n.pkt_dis;
        n.status = (s.status & ~clr) | ev;
        n.irq    = |(n.status & n.enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            s.eop <= EOP_IDLE;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    jlive_read_a: assert property (
        s.rsp.pready && !apb_i.pwrite && apb_i.paddr == CTRL_OFF
        |-> s.rsp.prdata[JLIVE_BIT] == $past(link_i.rx_j, 2))
        else $error("J flag read wrong");

    se0_read_a: assert property (
        s.rsp.pready && !apb_i.pwrite && apb_i.paddr == CTRL_OFF
        |-> s.rsp.prdata[SE0_BIT] == $past(link_i.rx_se0, 2))
        else $error("SE0 flag read wrong");

    setup_halt_a: assert property (
        link_i.setup_seen && !s.host_en && !($changed(n.host_en))
        |=> s.pkt_dis && s.lo.packet_halt && s.status[EV_SETUP])
        else $error("SETUP did not halt packets");

    token_busy_a: assert property (
        tok_ok |=> s.busy && s.lo.token_start ##1 !s.lo.token_start)
        else $error("Token busy not raised");

    bus_reset_a: assert property (
        wr && apb_i.paddr == CTRL_OFF
        |=> s.lo.bus_reset_drive ==
            ($past(apb_i.pwdata[BUSRST_BIT]) &&
             $past(apb_i.pwdata[HOST_CAPABILITY_ENABLE_BIT])))
        else $error("Bus reset drive wrong");

    host_mode_a: assert property (
        wr && apb_i.paddr == CTRL_OFF
        |=> s.lo.host_mode == $past(apb_i.pwdata[HOST_CAPABILITY_ENABLE_BIT]))
        else $error("Host mode wrong");

    host_toggle_a: assert property (
        $changed(s.host_en)
        |-> s.lo.host_logic_reset && !s.busy && s.eop == EOP_IDLE
            ##1 !s.lo.host_logic_reset)
        else $error("Host toggle did not reset");

    resume_drive_a: assert property (
        wr && apb_i.paddr == CTRL_OFF
        |=> s.lo.resume_drive == $past(apb_i.pwdata[RESUME_BIT]))
        else $error("Resume drive wrong");

    ls_eop_a: assert property (
        $fell(s.resume) && s.host_en && $past(s.host_en)
        |-> s.lo.eop_se0_drive [*8])
        else $error("No low-speed EOP after resume");

    high_zero_a: assert property (
        s.rsp.pready && !apb_i.pwrite && apb_i.paddr == CTRL_OFF
        |-> s.rsp.prdata[31:8] == 24'h000000)
        else $error("Upper control bits not zero");

    store_bits_a: assert property (
        wr && apb_i.paddr == CTRL_OFF
        |=> {s.store1, s.store0} ==
            $past(apb_i.pwdata[STORE1_BIT:STORE0_BIT]))
        else $error("Storage bits not written");

endmodule

// >>> tb/usb_peer_model.sv
`timescale 1ns/1ps
module usb_peer_model
    import usb_ctl_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire link_out_s link_o,
    input  wire logic      j_lvl,
    input  wire logic      se0_lvl,
    input  wire logic      setup_req,
    input  wire logic [7:0] tok_lat,
    output link_in_s       link_i
);
    logic [7:0] wait_r;
    logic       req_q;
    logic       setup_r;
    logic       done_r;
    logic       se0_w;
    logic       j_w;

    // ------------------------------------------------------------
    // Line levels
    // ------------------------------------------------------------
    // Lines pulled to SE0 while the module drives reset or the SE0 phase of EOP
    assign se0_w  = se0_lvl | link_o.bus_reset_drive | link_o.eop_se0_drive;
    assign j_w    = (j_lvl | link_o.eop_j_drive) & ~se0_w;
    assign link_i = '{j_w, se0_w, setup_r, done_r};

    // ------------------------------------------------------------
    // Token and setup events
    // ------------------------------------------------------------
    // Latency from tok_lat: 1 answers at once, larger values stall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {wait_r, req_q, setup_r, done_r} <= '0;
        end else begin
            req_q   <= setup_req;
            setup_r <= setup_req & ~req_q;
            done_r  <= (wait_r == 8'h01);
            if (link_o.token_start) begin
                wait_r <= tok_lat;
            end else if (wait_r != 8'h00) begin
                wait_r <= wait_r - 8'h01;
            end
        end
    end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import usb_ctl_pkg::*;
;
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    apb_req_s    req       = '0;
    apb_rsp_s    rsp;
    link_in_s    li;
    link_out_s   lo;
    logic        irq;
    logic        j_lvl     = 1'b0;
    logic        se0_lvl   = 1'b0;
    logic        setup_req = 1'b0;
    logic [7:0]  tok_lat   = 8'h14;
    logic [31:0] rd;
    logic        err;
    int          num_errors   = 0;
    int          total_checks = 0;
    int          hlr_n = 0;
    int          se0_n = 0;
    int          j_n   = 0;
    int          s0;
    int          s1;
    int          i;
    logic [11:0] row_a [6] = '{CTRL_OFF, CTRL_OFF, CTRL_OFF, CTRL_OFF,
                               IRQ_EN_OFF, IRQ_CLR_OFF};
    logic [31:0] row_d [6] = '{32'hFFFFFF03, 32'h00000020, 32'h000000C0,
                               32'h00000004, 32'hFFFFFFFF, 32'h00000007};
    logic [31:0] row_e [6] = '{32'h03, 32'h20, 32'h00, 32'h04, 32'h07, 32'h00};

    always #12.5 pclk = ~pclk;

    // Pulse and phase counters; phase counts compared as differences, hlr_n as a total
    always @(posedge pclk) begin
        hlr_n <= hlr_n + int'(lo.host_logic_reset === 1'b1);
        se0_n <= se0_n + int'(lo.eop_se0_drive === 1'b1);
        j_n   <= j_n + int'(lo.eop_j_drive === 1'b1);
    end

    usb_control_register_logic i_dut (
        .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
        .link_i(li), .link_o(lo), .irq_o(irq));

    usb_peer_model i_peer (
        .pclk(pclk), .presetn(presetn), .link_o(lo), .j_lvl(j_lvl),
        .se0_lvl(se0_lvl), .setup_req(setup_req), .tok_lat(tok_lat),
        .link_i(li));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // No fixed wait: holds the access until pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task tally_and_finish;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        chk(lo, 32'h0);
        presetn <= 1'b1;
        rc(CTRL_OFF, 32'h0);
        for (int k = 0; k < 6; k++) begin
            wr(row_a[k], row_d[k]);
            rc(row_a[k], row_e[k]);
        end
        chk(lo.resume_drive, 1);
        wr(CTRL_OFF, 32'h0);
        chk(lo.eop_se0_drive | lo.resume_drive, 0);
        j_lvl <= 1'b1;
        rc(CTRL_OFF, 32'h80);
        j_lvl <= 1'b0;
        se0_lvl <= 1'b1;
        rc(CTRL_OFF, 32'h40);
        se0_lvl <= 1'b0;
        setup_req <= 1'b1;
        rc(CTRL_OFF, 32'h20);
        setup_req <= 1'b0;
        chk({lo.packet_halt, irq}, 2'b11);
        rc(IRQ_STAT_OFF, 32'h1);
        wr(IRQ_CLR_OFF, 32'h1);
        chk(irq, 0);
        wr(CTRL_OFF, 32'h0);
        chk(lo.packet_halt, 0);
        wr(CTRL_OFF, 32'h08);
        chk({lo.host_mode, lo.packet_halt}, 2'b10);
        // Counter updates on the same edge that ends the write
        @(posedge pclk);
        chk(hlr_n, 1);
        wr(TOKEN_OFF, 32'h5A);
        wr(TOKEN_OFF, 32'hA5);
        rc(CTRL_OFF, 32'h28);
        chk(lo.token_cmd, 8'h5A);
        i = 0;
        do begin
            apb(1'b0, CTRL_OFF, 32'h0);
            i++;
        end while (rd[PACKET_PROCESSING_DISABLE_BIT] !== 1'b0 && i < 40);
        chk(rd, 32'h08);
        rc(IRQ_STAT_OFF, 32'h2);
        tok_lat <= 8'h01;
        wr(TOKEN_OFF, 32'hC3);
        rc(CTRL_OFF, 32'h08);
        chk(lo.token_cmd, 8'hC3);
        wr(CTRL_OFF, 32'h18);
        chk(lo.bus_reset_drive, 1);
        rc(CTRL_OFF, 32'h58);
        wr(CTRL_OFF, 32'h08);
        chk(lo.bus_reset_drive, 0);
        // Resume hold cut short; real software holds it for milliseconds
        wr(CTRL_OFF, 32'h0C);
        chk(lo.resume_drive, 1);
        wr(IRQ_CLR_OFF, 32'h7);
        s0 = se0_n;
        s1 = j_n;
        wr(CTRL_OFF, 32'h08);
        repeat (100) @(posedge pclk);
        chk(se0_n - s0, 54);
        chk(j_n - s1, 27);
        chk({lo.resume_drive, irq}, 2'b01);
        rc(IRQ_STAT_OFF, 32'h4);
        wr(CTRL_OFF, 32'h0);
        @(posedge pclk);
        chk({lo.host_mode, hlr_n[1:0]}, 3'b010);
        apb(1'b0, 12'h020, 32'h0);
        chk(err, 1);
        tally_and_finish;
    end

    initial begin
        repeat (3000) @(posedge pclk);
        num_errors++;
        tally_and_finish;
    end
endmodule
